// ### logic/css_defines.svh
// constants for the clock source and start-up sequencer
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// register byte offsets on the avalon slave
`define CSS_REG_FUSE     4'h0
`define CSS_REG_SLEEP    4'h4
`define CSS_REG_STATUS   4'h8
`define CSS_REG_DOMAIN   4'hc

// fuse register layout and factory value (rc 8 MHz, sut 10, div8 programmed)
`define CSS_FUSE_CKSEL_LSB 0
`define CSS_FUSE_SUT_LSB   4
`define CSS_FUSE_DIV8_BIT  7
`define CSS_FUSE_RESET     8'h22

// sleep register layout
`define CSS_SLEEP_MODE_LSB 0
`define CSS_SLEEP_GO_BIT   4
`define CSS_SLEEP_RESET    3'h0

// clock source select codes
`define CSS_SRC_EXT      4'h0
`define CSS_SRC_RSVD     4'h1
`define CSS_SRC_RC8      4'h2
`define CSS_SRC_RC128    4'h3

// start-up counts in oscillator cycles
`define CSS_STARTUP_6    16'h0006
`define CSS_STARTUP_258  16'h0102
`define CSS_STARTUP_1K   16'h0400
`define CSS_EXTRA_CK     16'h000e

// supply time-out in watchdog oscillator cycles
`define CSS_TOUT_SHORT   14'h1000

// system prescaler terminal count for divide by eight
`define CSS_DIV8_LAST    3'h7

`endif

// ### logic/css_pkg.sv
// types for the clock source and start-up sequencer
`default_nettype none
package css_pkg;

  typedef enum logic [2:0] {
    SRC_LP_XTAL, SRC_FS_XTAL, SRC_LF_XTAL, SRC_RC128, SRC_RC8, SRC_EXT, SRC_RSVD
  } css_src_e;

  typedef enum logic [1:0] {TOUT_NONE, TOUT_SHORT, TOUT_LONG} css_tout_e;

  typedef enum logic [2:0] {
    SLP_IDLE, SLP_ADC_NR, SLP_PDOWN, SLP_PSAVE, SLP_STANDBY
  } css_sleep_e;

  typedef enum logic [2:0] {
    SEQ_HOLD, SEQ_TIMEOUT, SEQ_STARTUP, SEQ_RUN, SEQ_SLEEP
  } css_seq_e;

  typedef struct packed {
    logic       div8;   // 0 = programmed
    logic [1:0] sut;
    logic [3:0] cksel;
  } css_fuse_s;

  typedef struct packed {
    logic cpu;
    logic io;
    logic flash;
    logic asy;
    logic adc;
  } css_domain_s;

  typedef struct packed {
    css_tout_e   tout;
    logic [15:0] osc_cycles;
  } css_startup_s;

endpackage : css_pkg
`default_nettype wire

// ### logic/css_sequencer.sv
// clock source selection, domain gating and reset start-up sequencer
`include "css_defines.svh"
`default_nettype none

// Contract
// RULE1 - crystal fuse ranges pick three crystal modes
// RULE2 - codes 0011 0010 0000 pick internal/external
// RULE3 - fuse bit zero means programmed
// RULE4 - factory default rc, div8, sut 10
// RULE5 - hold internal reset after other sources
// RULE6 - time-out counted on watchdog oscillator
// RULE7 - time-out lengths 0, 4096, 8192
// RULE8 - count oscillator cycles before reset release
// RULE9 - reset start applies time-out and start-up
// RULE10 - sleep wake applies start-up count only
// RULE11 - start-up count from 6 to 32K
// RULE12 - low power crystal range from bits three-one
// RULE13 - low power crystal start-up count table
// RULE14 - add 14 cycles plus selected time-out
// RULE15 - gate five domains per sleep mode
// RULE16 - memory clock follows core clock
// RULE17 - async timer runs from own clock
// RULE18 - converter clock runs in noise mode
// RULE19 - wake interrupt seen with io halted
// RULE20 - divide system clock by eight when programmed
// RULE21 - configurer picks time-out above supply rise
// RULE22 - low frequency crystal count 1K or 32K
// RULE23 - any reset reassertion restarts both counters
module css_sequencer
  import css_pkg::*;
#(
  parameter logic [13:0] TOUT_LONG_CYCLES = 14'h2000,
  parameter logic [15:0] STARTUP_16K      = 16'h4000,
  parameter logic [15:0] STARTUP_32K      = 16'h8000
)(
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // oscillator and event pins
  input  wire logic        oscillator_amp_input,
  input  wire logic        rc8_osc_in,
  input  wire logic        rc128_osc_in,
  input  wire logic        wdt_osc_in,
  input  wire logic        async_timer_clock,
  input  wire logic        reset_request,
  input  wire logic        ext_wake_irq,
  // outputs
  output logic             internal_reset,
  output css_domain_s      domain_clk_en,
  output css_src_e         osc_mode,
  output logic [2:0]       crystal_range_select_fuses
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode functions

  // fuse field to clock source
  function automatic css_src_e decode_source(input logic [3:0] cksel);
    css_src_e s;
    s = SRC_RSVD;
    // RULE1 crystal code ranges
    if (cksel[3])
      s = SRC_LP_XTAL;
    else if (cksel[3:1] == 3'h3)
      s = SRC_FS_XTAL;
    else if (cksel[3:1] == 3'h2)
      s = SRC_LF_XTAL;
    // RULE2 internal and external codes
    else if (cksel == `CSS_SRC_RC128)
      s = SRC_RC128;
    else if (cksel == `CSS_SRC_RC8)
      s = SRC_RC8;
    else if (cksel == `CSS_SRC_EXT)
      s = SRC_EXT;
    return s;
  endfunction : decode_source

  // sut plus selection to start-up count and time-out
  function automatic css_startup_s decode_startup(input css_fuse_s f);
    css_startup_s r;
    css_src_e     s;
    s = decode_source(f.cksel);
    r.tout       = TOUT_LONG;
    r.osc_cycles = `CSS_STARTUP_6;
    case (s)
      SRC_LP_XTAL, SRC_FS_XTAL:
      begin
        // RULE13 crystal count table
        case ({f.cksel[0], f.sut})
          3'h0:    begin r.osc_cycles = `CSS_STARTUP_258; r.tout = TOUT_SHORT; end
          3'h1:    begin r.osc_cycles = `CSS_STARTUP_258; r.tout = TOUT_LONG;  end
          3'h2:    begin r.osc_cycles = `CSS_STARTUP_1K;  r.tout = TOUT_NONE;  end
          3'h3:    begin r.osc_cycles = `CSS_STARTUP_1K;  r.tout = TOUT_SHORT; end
          3'h4:    begin r.osc_cycles = `CSS_STARTUP_1K;  r.tout = TOUT_LONG;  end
          3'h5:    begin r.osc_cycles = STARTUP_16K;      r.tout = TOUT_NONE;  end
          3'h6:    begin r.osc_cycles = STARTUP_16K;      r.tout = TOUT_SHORT; end
          default: begin r.osc_cycles = STARTUP_16K;      r.tout = TOUT_LONG;  end
        endcase
      end
      SRC_LF_XTAL:
      begin
        // RULE22 1K or 32K by low bit
        r.osc_cycles = f.cksel[0] ? STARTUP_32K : `CSS_STARTUP_1K;
        r.tout       = (f.sut == 2'h0) ? TOUT_NONE :
                       (f.sut == 2'h1) ? TOUT_SHORT : TOUT_LONG;
      end
      default:
      begin
        // RULE11 six cycles for rc and external
        r.osc_cycles = `CSS_STARTUP_6;
        r.tout       = (f.sut == 2'h0) ? TOUT_NONE :
                       (f.sut == 2'h1) ? TOUT_SHORT : TOUT_LONG;
      end
    endcase
    return r;
  endfunction : decode_startup

  // domains running in a sequencer state and sleep mode
  function automatic css_domain_s domain_mask(input css_seq_e st, input css_sleep_e m);
    css_domain_s d;
    d = '0;
    if (st == SEQ_RUN)
      d = '1;
    else if (st == SEQ_SLEEP)
    begin
      // RULE15 per-mode gating
      case (m)
        SLP_IDLE:   begin d.io = 1'b1; d.asy = 1'b1; d.adc = 1'b1; end
        // RULE18 converter alive in noise mode
        SLP_ADC_NR: begin d.asy = 1'b1; d.adc = 1'b1; end
        // RULE17 timer keeps counting
        SLP_PSAVE:  d.asy = 1'b1;
        default:    d = '0;
      endcase
    end
    // RULE16 memory follows core
    d.flash = d.cpu;
    return d;
  endfunction : domain_mask

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_rise;

  assign pin_raw = {ext_wake_irq, reset_request, async_timer_clock, wdt_osc_in,
                    rc128_osc_in, rc8_osc_in, oscillator_amp_input};

  // two flops then an edge history flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // rising edges of every synced pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_edge
      assign pin_rise[gi] = pin_s2[gi] & ~pin_s3[gi];
    end
  endgenerate

  logic xtal_rise;
  logic rc8_rise;
  logic rc128_rise;
  logic wdt_rise;
  logic asy_rise;
  logic reset_req_s;
  logic wake_s;

  assign xtal_rise   = pin_rise[0];
  assign rc8_rise    = pin_rise[1];
  assign rc128_rise  = pin_rise[2];
  assign wdt_rise    = pin_rise[3];
  assign asy_rise    = pin_rise[4];
  assign reset_req_s = pin_s2[5];
  // RULE19 wake seen on the always-running fabric clock
  assign wake_s      = pin_s2[6];

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave and software registers

  css_fuse_s  fuse_reg;
  css_sleep_e sleep_mode_reg;
  logic       sleep_go;
  logic       bus_ack;
  logic       bus_req;
  logic       wr_low;

  // factory fuse image as a sized constant, so its fields can be selected
  localparam logic [7:0] FUSE_DEFAULT = `CSS_FUSE_RESET;

  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign wr_low          = avs_write & bus_ack & avs_byteenable[0];

  // one wait state per access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_ack <= 1'b0;
    else
      bus_ack <= bus_req & ~bus_ack;
  end

  // fuse image, only sampled while reset is held
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      // RULE4 factory default image
      fuse_reg <= css_fuse_s'({FUSE_DEFAULT[`CSS_FUSE_DIV8_BIT],
                               FUSE_DEFAULT[`CSS_FUSE_SUT_LSB +: 2],
                               FUSE_DEFAULT[`CSS_FUSE_CKSEL_LSB +: 4]});
    else if (wr_low && avs_address == `CSS_REG_FUSE)
      fuse_reg <= css_fuse_s'({avs_writedata[`CSS_FUSE_DIV8_BIT],
                               avs_writedata[`CSS_FUSE_SUT_LSB +: 2],
                               avs_writedata[`CSS_FUSE_CKSEL_LSB +: 4]});
  end

  // sleep mode and one-cycle sleep request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_mode_reg <= css_sleep_e'(`CSS_SLEEP_RESET);
      sleep_go       <= 1'b0;
    end
    else
    begin
      sleep_go <= 1'b0;
      if (wr_low && avs_address == `CSS_REG_SLEEP)
      begin
        sleep_mode_reg <= css_sleep_e'(avs_writedata[`CSS_SLEEP_MODE_LSB +: 3]);
        sleep_go       <= avs_writedata[`CSS_SLEEP_GO_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start-up sequencer

  css_seq_e     seq;
  css_fuse_s    active_fuse;
  css_sleep_e   sleep_mode_q;
  logic         from_reset;
  logic [13:0]  tout_cnt;
  logic [15:0]  osc_cnt;
  logic [15:0]  osc_target;
  logic [13:0]  tout_target;
  logic         osc_rise;
  css_src_e     active_src;
  css_startup_s active_su;
  css_startup_s fuse_su;

  assign active_src = decode_source(active_fuse.cksel);
  assign active_su  = decode_startup(active_fuse);
  assign fuse_su    = decode_startup(fuse_reg);

  // RULE14 fourteen extra cycles from reset only
  assign osc_target  = from_reset ? 16'(active_su.osc_cycles + `CSS_EXTRA_CK)
                                  : active_su.osc_cycles;
  // RULE7 short and long time-out lengths
  assign tout_target = (active_su.tout == TOUT_SHORT) ? `CSS_TOUT_SHORT : TOUT_LONG_CYCLES;

  // selected oscillator edge
  always_comb
  begin
    case (active_src)
      SRC_RC8, SRC_RSVD: osc_rise = rc8_rise;
      SRC_RC128:         osc_rise = rc128_rise;
      default:           osc_rise = xtal_rise;
    endcase
  end

  // sequencer state and counters
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq          <= SEQ_HOLD;
      active_fuse  <= '0;
      sleep_mode_q <= SLP_IDLE;
      from_reset   <= 1'b1;
      tout_cnt     <= '0;
      osc_cnt      <= '0;
    end
    else if (reset_req_s)
    begin
      // RULE23 reassertion restarts counting
      seq        <= SEQ_HOLD;
      from_reset <= 1'b1;
      tout_cnt   <= '0;
      osc_cnt    <= '0;
    end
    else
    begin
      case (seq)
        SEQ_HOLD:
        begin
          // RULE5 reset held past other sources
          active_fuse <= fuse_reg;
          from_reset  <= 1'b1;
          tout_cnt    <= '0;
          osc_cnt     <= '0;
          // RULE9 time-out first, then start-up
          seq <= (fuse_su.tout == TOUT_NONE) ? SEQ_STARTUP : SEQ_TIMEOUT;
        end
        SEQ_TIMEOUT:
        begin
          // RULE6 counted on watchdog edges
          if (wdt_rise)
          begin
            if (tout_cnt == 14'(tout_target - 14'h1))
            begin
              tout_cnt <= '0;
              seq      <= SEQ_STARTUP;
            end
            else
              tout_cnt <= tout_cnt + 14'h1;
          end
        end
        SEQ_STARTUP:
        begin
          // RULE8 count selected oscillator cycles
          if (osc_rise)
          begin
            if (osc_cnt == 16'(osc_target - 16'h1))
            begin
              osc_cnt <= '0;
              seq     <= SEQ_RUN;
            end
            else
              osc_cnt <= osc_cnt + 16'h1;
          end
        end
        SEQ_RUN:
        begin
          if (sleep_go)
          begin
            sleep_mode_q <= sleep_mode_reg;
            seq          <= SEQ_SLEEP;
          end
        end
        SEQ_SLEEP:
        begin
          if (wake_s)
          begin
            if (sleep_mode_q == SLP_IDLE || sleep_mode_q == SLP_ADC_NR)
              seq <= SEQ_RUN;
            else
            begin
              // RULE10 wake skips the supply time-out
              from_reset <= 1'b0;
              osc_cnt    <= '0;
              seq        <= SEQ_STARTUP;
            end
          end
        end
        default:
          seq <= SEQ_HOLD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // system prescaler and domain strobes

  logic [2:0]  presc;
  logic        div8_on;
  logic        sys_tick;
  css_domain_s dom;

  // RULE3 zero means programmed
  assign div8_on  = ~active_fuse.div8;
  // RULE20 divide by eight when programmed
  assign sys_tick = osc_rise & (~div8_on | (presc == `CSS_DIV8_LAST));
  assign dom      = domain_mask(seq, sleep_mode_q);

  // prescaler runs on the selected oscillator
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      presc <= '0;
    else if (seq == SEQ_HOLD)
      presc <= '0;
    else if (osc_rise)
      presc <= presc + 3'h1;
  end

  // registered clock enables for each domain
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      domain_clk_en <= '0;
    else
    begin
      // RULE15 halted domains get no strobes
      domain_clk_en.cpu   <= dom.cpu & sys_tick;
      domain_clk_en.io    <= dom.io & sys_tick;
      domain_clk_en.flash <= dom.flash & sys_tick;
      domain_clk_en.adc   <= dom.adc & sys_tick;
      // RULE17 timer strobes from its own pin
      domain_clk_en.asy   <= dom.asy & asy_rise;
    end
  end

  // reset output and mode reporting
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      internal_reset             <= 1'b1;
      osc_mode                   <= SRC_RSVD;
      crystal_range_select_fuses <= '0;
    end
    else
    begin
      // RULE5 released only after start-up count
      internal_reset <= ~(seq == SEQ_RUN || seq == SEQ_SLEEP);
      osc_mode       <= active_src;
      // RULE12 range from upper select bits
      crystal_range_select_fuses <= (active_src == SRC_LP_XTAL) ? active_fuse.cksel[3:1]
                                                                : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= '0;
    else if (avs_read && !bus_ack)
    begin
      if (avs_address == `CSS_REG_FUSE)
        avs_readdata <= {24'h0, fuse_reg.div8, 1'b0, fuse_reg.sut, fuse_reg.cksel};
      else if (avs_address == `CSS_REG_SLEEP)
        avs_readdata <= {29'h0, sleep_mode_reg};
      else if (avs_address == `CSS_REG_STATUS)
        avs_readdata <= {24'h0, from_reset, active_src, internal_reset, seq};
      else if (avs_address == `CSS_REG_DOMAIN)
        avs_readdata <= {27'h0, dom};
      else
        avs_readdata <= '0;
    end
  end

endmodule : css_sequencer
`default_nettype wire

// ### bench/css_sequencer_sva.sv
// concurrent checks on the sequencer ports
`default_nettype none
module css_sequencer_sva
  import css_pkg::*;
#(
  parameter logic [13:0] TOUT_LONG_CYCLES = 14'h2000,
  parameter logic [15:0] STARTUP_16K      = 16'h4000,
  parameter logic [15:0] STARTUP_32K      = 16'h8000
)(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        reset_request,
  input wire logic        internal_reset,
  input wire css_domain_s domain_clk_en,
  input wire css_src_e    osc_mode,
  input wire logic [2:0]  crystal_range_select_fuses
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, none when idle
  property p_wait_new;
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_new: assert property (p_wait_new)
    else $error("new request not stalled");
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("more than one wait state");
  property p_wait_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest without request");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////////
  // source decode and domain relations
  property p_range;
    osc_mode != SRC_LP_XTAL |-> crystal_range_select_fuses == 3'h0;
  endproperty
  a_range: assert property (p_range)
    else $error("range set outside low power crystal");
  property p_flash;
    domain_clk_en.flash == domain_clk_en.cpu;
  endproperty
  a_flash: assert property (p_flash)
    else $error("memory clock differs from core clock");
  property p_cpu_gap;
    domain_clk_en.cpu |=> !domain_clk_en.cpu [*3];
  endproperty
  a_cpu_gap: assert property (p_cpu_gap)
    else $error("core strobes too close");

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and restart
  property p_fall_clean;
    $fell(internal_reset) |->
      !$past(reset_request, 1) && !$past(reset_request, 2) && !$past(reset_request, 3);
  endproperty
  a_fall_clean: assert property (p_fall_clean)
    else $error("reset released while source active");
  property p_restart;
    reset_request [*6] |-> internal_reset;
  endproperty
  a_restart: assert property (p_restart)
    else $error("reset request not restarting");
  property p_min_hold;
    $rose(internal_reset) |=> internal_reset [*8];
  endproperty
  a_min_hold: assert property (p_min_hold)
    else $error("internal reset too short");
endmodule : css_sequencer_sva

bind css_sequencer css_sequencer_sva #(
  .TOUT_LONG_CYCLES(TOUT_LONG_CYCLES),
  .STARTUP_16K(STARTUP_16K),
  .STARTUP_32K(STARTUP_32K)
) u_sva (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .reset_request(reset_request), .internal_reset(internal_reset),
  .domain_clk_en(domain_clk_en), .osc_mode(osc_mode),
  .crystal_range_select_fuses(crystal_range_select_fuses)
);
`default_nettype wire

// ### bench/css_osc_model.sv
// clock source model driving the oscillator pins
`default_nettype none
module css_osc_model (
  input  wire logic clk,
  output logic      oscillator_amp_input,
  output logic      rc8_osc_in,
  output logic      rc128_osc_in,
  output logic      wdt_osc_in,
  output logic      async_timer_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] phase = 4'h0;

  // free-running divider sets each source rate
  always_ff @(posedge clk)
  begin
    phase <= phase + 4'h1;
  end

  // crystal and rc8 sources: four clk period
  assign oscillator_amp_input = phase[1];
  assign rc8_osc_in           = phase[1];
  // watchdog and 128k sources: eight clk period
  assign wdt_osc_in           = phase[2];
  assign rc128_osc_in         = phase[2];
  assign async_timer_clock    = phase[3];
endmodule : css_osc_model
`default_nettype wire

// ### bench/css_sequencer_bench.sv
// self-checking bench for the clock source sequencer
`include "css_defines.svh"
`default_nettype none
module css_sequencer_bench
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] cksel; css_src_e mode; logic [2:0] rng;} css_row_s;
  typedef struct packed {logic [2:0] mode; logic [4:0] mask;} css_slp_s;
  localparam css_row_s ROWS [10] = '{'{4'hf, SRC_LP_XTAL, 3'h7}, '{4'h8, SRC_LP_XTAL, 3'h4},
    '{4'h7, SRC_FS_XTAL, 3'h0}, '{4'h6, SRC_FS_XTAL, 3'h0}, '{4'h5, SRC_LF_XTAL, 3'h0},
    '{4'h4, SRC_LF_XTAL, 3'h0}, '{4'h3, SRC_RC128, 3'h0}, '{4'h2, SRC_RC8, 3'h0},
    '{4'h0, SRC_EXT, 3'h0}, '{4'h1, SRC_RSVD, 3'h0}};
  localparam css_slp_s SLP [5] = '{'{3'h0, 5'h0b}, '{3'h1, 5'h03}, '{3'h2, 5'h00},
    '{3'h3, 5'h02}, '{3'h4, 5'h00}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        osc_x, osc_rc8, osc_rc128, osc_wdt, osc_asy;
  logic        reset_request = 1'b0;
  logic        ext_wake_irq = 1'b0;
  logic        internal_reset;
  css_domain_s domain_clk_en;
  css_src_e    osc_mode;
  logic [2:0]  range_sel;
  logic [31:0] rd;
  logic [4:0]  seen;
  int          errors = 0;
  int          cmp_count = 0;
  int          n;

  always #20 clk = ~clk;

  css_sequencer #(.TOUT_LONG_CYCLES(14'h20), .STARTUP_16K(16'h40), .STARTUP_32K(16'h80)) dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .oscillator_amp_input(osc_x), .rc8_osc_in(osc_rc8), .rc128_osc_in(osc_rc128),
    .wdt_osc_in(osc_wdt), .async_timer_clock(osc_asy), .reset_request(reset_request),
    .ext_wake_irq(ext_wake_irq), .internal_reset(internal_reset),
    .domain_clk_en(domain_clk_en), .osc_mode(osc_mode), .crystal_range_select_fuses(range_sel));

  css_osc_model u_osc (.clk(clk), .oscillator_amp_input(osc_x), .rc8_osc_in(osc_rc8),
    .rc128_osc_in(osc_rc128), .wdt_osc_in(osc_wdt), .async_timer_clock(osc_asy));

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wait_clk(input int k);
    repeat (k) @(posedge clk);
  endtask : wait_clk

  // one avalon transfer held until waitrequest is low
  task bus(input logic wr, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // load fuses, then hold the other reset sources
  task restart(input logic [7:0] fuse);
    bus(1'b1, `CSS_REG_FUSE, 4'h1, {24'h0, fuse});
    reset_request <= 1'b1;
    wait_clk(8);
    reset_request <= 1'b0;
  endtask : restart

  task wait_run(input int k);
    n = 0;
    while (internal_reset !== 1'b0 && n < k)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_run

  task end_sim;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    wait_clk(10);
    chk(internal_reset, 1'b1, "reset held");
    chk(domain_clk_en, 5'h00, "reset domains");
    chk(osc_mode, SRC_RSVD, "reset osc_mode");
    rst <= 1'b0;
    bus(1'b0, `CSS_REG_FUSE, 4'hf, 32'h0);
    chk(rd, 32'h22, "fuse default");
    foreach (ROWS[i])
    begin
      restart({4'ha, ROWS[i].cksel});
      wait_clk(10);
      chk(osc_mode, ROWS[i].mode, "osc_mode");
      chk(range_sel, ROWS[i].rng, "range");
    end
    // default fuses, restarted in mid time-out
    restart(8'h22);
    wait_clk(100);
    reset_request <= 1'b1;
    wait_clk(8);
    reset_request <= 1'b0;
    wait_clk(300);
    chk(internal_reset, 1'b1, "held through time-out");
    wait_run(150);
    chk(internal_reset, 1'b0, "released");
    chk(osc_mode, SRC_RC8, "default source");
    n = 0;
    repeat (320)
    begin
      @(negedge clk);
      n = n + domain_clk_en.cpu;
    end
    chk(n >= 9 && n <= 11, 1'b1, "core strobes divided");
    foreach (SLP[i])
    begin
      bus(1'b1, `CSS_REG_SLEEP, 4'h1, {27'h0, 2'h2, SLP[i].mode});
      wait_clk(4);
      seen = 5'h0;
      repeat (96)
      begin
        @(negedge clk);
        seen = seen | domain_clk_en;
      end
      chk(seen, SLP[i].mask, "sleep domains");
      @(posedge clk);
      ext_wake_irq <= 1'b1;
      wait_clk(4);
      ext_wake_irq <= 1'b0;
      wait_clk(80);
      bus(1'b0, `CSS_REG_STATUS, 4'hf, 32'h0);
      chk(rd[2:0], 3'h3, "run after wake");
    end
    // refused writes and unmapped places
    bus(1'b1, `CSS_REG_FUSE, 4'he, 32'h0);
    bus(1'b1, `CSS_REG_STATUS, 4'hf, 32'hff);
    bus(1'b1, 4'h2, 4'hf, 32'hff);
    bus(1'b0, `CSS_REG_FUSE, 4'hf, 32'h0);
    chk(rd, 32'h22, "fuse kept");
    bus(1'b0, 4'h6, 4'hf, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    // no time-out only with brown-out guard
    restart(8'ha8);
    wait_clk(4100);
    chk(internal_reset, 1'b1, "crystal start-up held");
    wait_run(200);
    chk(internal_reset, 1'b0, "crystal start-up done");
    end_sim();
  end

  // watchdog against a hang
  initial
  begin
    wait_clk(20000);
    errors++;
    end_sim();
  end
endmodule : css_sequencer_bench
`default_nettype wire
